// *** design/pmdec_decimator.sv ***
// Two-channel PDM to 16 kHz PCM decimator with DC blocker and gain
`include "pmdec_params.svh"

module pmdec_decimator
    import pmdec_pkg::*;
(
    input wire logic i_clock,              // 200 MHz system clock
    input wire logic i_arst_n,             // Async reset, active low
    input wire logic i_mic_clk,            // Microphone bit clock
    input wire logic i_mic_data,           // Shared PDM data line
    input wire logic i_cfg_wr,             // Gain write strobe
    input wire logic [31:0] i_cfg_shift,   // Shift argument, low 6 bits signed
    input wire logic [31:0] i_cfg_sat,     // Saturate argument, nonzero enables
    input wire logic i_cfg_rd,             // Gain read strobe
    output logic o_cfg_rd_valid,           // Read answer pulse
    output logic [31:0] o_cfg_shift,       // Read shift, sign extended
    output logic [31:0] o_cfg_sat,         // Read saturate, 0 or 1
    output logic o_pcm_valid,              // PCM frame available
    input wire logic i_pcm_ready,          // Pipeline takes frame
    output pmdec_frame_t o_pcm,            // PCM frame, both channels
    output logic o_overrun                 // Sticky, a frame was lost
);
    localparam int SW = `PMDEC_SAMPLE_W;

    // Pin synchronisers and edge detect
    logic [2:0] clk_sync_reg, clk_sync_next;
    logic [1:0] dat_sync_reg, dat_sync_next;
    logic bit0_reg, bit0_next;
    logic mic_rise, mic_fall;

    always_comb begin
        clk_sync_next = {clk_sync_reg[1:0], i_mic_clk};
        dat_sync_next = {dat_sync_reg[0], i_mic_data};
        mic_rise = clk_sync_reg[1] && !clk_sync_reg[2];
        mic_fall = !clk_sync_reg[1] && clk_sync_reg[2];
        bit0_next = mic_rise ? dat_sync_reg[1] : bit0_reg;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clk_sync_reg <= 3'h0;
            dat_sync_reg <= 2'h0;
            bit0_reg <= 1'b0;
        end else begin
            clk_sync_reg <= clk_sync_next;
            dat_sync_reg <= dat_sync_next;
            bit0_reg <= bit0_next;
        end
    end

    // Gain configuration
    pmdec_gain_t gain_reg, gain_next;
    logic rd_valid_reg, rd_valid_next;
    logic [31:0] rd_shift_reg, rd_shift_next, rd_sat_reg, rd_sat_next;

    always_comb begin
        gain_next = gain_reg;
        if (i_cfg_wr) begin
            gain_next.shift = i_cfg_shift[5:0];
            gain_next.sat = (i_cfg_sat != 32'h0);
        end
        rd_valid_next = i_cfg_rd;
        rd_shift_next = i_cfg_rd ? 32'(gain_reg.shift) : rd_shift_reg;
        rd_sat_next = i_cfg_rd ? {31'h0, gain_reg.sat} : rd_sat_reg;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gain_reg <= {`PMDEC_SHIFT_RST, `PMDEC_SAT_RST};
            rd_valid_reg <= 1'b0;
            rd_shift_reg <= 32'h0;
            rd_sat_reg <= 32'h0;
        end else begin
            gain_reg <= gain_next;
            rd_valid_reg <= rd_valid_next;
            rd_shift_reg <= rd_shift_next;
            rd_sat_reg <= rd_sat_next;
        end
    end

    // Power-of-two gain with optional clamp
    function automatic logic signed [SW-1:0] apply_gain(
        input logic signed [SW-1:0] x,
        input logic signed [5:0] sh,
        input logic sat
    );
        logic signed [2*SW-1:0] wide;
        logic signed [2*SW-1:0] hi;
        logic signed [2*SW-1:0] lo;
        wide = 64'(x);
        hi = 64'(32'sh7fffffff);
        lo = -64'(32'sh7fffffff) - 64'sh1;
        if (sh >= 6'sh0) begin
            wide = wide <<< sh;
            if (sat && sh != 6'sh0 && wide > hi) begin
                apply_gain = 32'sh7fffffff;
            end else if (sat && sh != 6'sh0 && wide < lo) begin
                apply_gain = 32'sh80000000;
            end else begin
                apply_gain = wide[SW-1:0];
            end
        end else begin
            apply_gain = x >>> (-sh);
        end
    endfunction : apply_gain

    // Decimation chain, DC blocker and output slot
    logic [2:0] cnt1_reg, cnt1_next;
    logic [1:0] cnt2_reg, cnt2_next;
    logic [2:0] cnt3_reg, cnt3_next;
    logic signed [SW-1:0] acc1_reg [2], acc1_next [2];
    logic signed [SW-1:0] acc2_reg [2], acc2_next [2];
    logic signed [SW-1:0] acc3_reg [2], acc3_next [2];
    logic signed [SW-1:0] xp_reg [2], xp_next [2];
    logic signed [SW-1:0] yp_reg [2], yp_next [2];
    logic signed [SW-1:0] out1 [2], out2 [2], out3 [2], dc_y [2];
    logic signed [SW-1:0] xs [2];
    logic s1_fire, s2_fire, s3_fire;
    pmdec_frame_t pend_reg, pend_next;
    logic pend_valid_reg, pend_valid_next;
    logic overrun_reg, overrun_next;
    logic slot_busy;
    logic fifo_ready;
    logic [1:0] pdm_bit;

    always_comb begin
        cnt1_next = cnt1_reg;
        cnt2_next = cnt2_reg;
        cnt3_next = cnt3_reg;
        acc1_next = acc1_reg;
        acc2_next = acc2_reg;
        acc3_next = acc3_reg;
        xp_next = xp_reg;
        yp_next = yp_reg;
        s1_fire = 1'b0;
        s2_fire = 1'b0;
        s3_fire = 1'b0;
        pdm_bit = {dat_sync_reg[1], bit0_reg};
        for (int c = 0; c < 2; c++) begin
            out1[c] = acc1_reg[c] + (pdm_bit[c] ? 32'sh1 : -32'sh1);
            out2[c] = acc2_reg[c] + out1[c];
            out3[c] = acc3_reg[c] + out2[c];
            // Headroom shift: small sums would stall the pole term's decay
            xs[c] = out3[c] <<< `PMDEC_DCB_IN_SHIFT;
            dc_y[c] = xs[c] - xp_reg[c] + yp_reg[c] - (yp_reg[c] >>> `PMDEC_DCB_SHIFT);
        end
        if (mic_fall) begin
            s1_fire = (cnt1_reg == 3'(`PMDEC_DEC1 - 1));
            cnt1_next = s1_fire ? 3'h0 : cnt1_reg + 3'h1;
            for (int c = 0; c < 2; c++) begin
                acc1_next[c] = s1_fire ? 32'sh0 : out1[c];
            end
        end
        if (s1_fire) begin
            s2_fire = (cnt2_reg == 2'(`PMDEC_DEC2 - 1));
            cnt2_next = s2_fire ? 2'h0 : cnt2_reg + 2'h1;
            for (int c = 0; c < 2; c++) begin
                acc2_next[c] = s2_fire ? 32'sh0 : out2[c];
            end
        end
        if (s2_fire) begin
            s3_fire = (cnt3_reg == 3'(`PMDEC_DEC3 - 1));
            cnt3_next = s3_fire ? 3'h0 : cnt3_reg + 3'h1;
            for (int c = 0; c < 2; c++) begin
                acc3_next[c] = s3_fire ? 32'sh0 : out3[c];
            end
        end
        if (s3_fire) begin
            for (int c = 0; c < 2; c++) begin
                xp_next[c] = xs[c];
                yp_next[c] = dc_y[c];
            end
        end
        // Slot drains into the FIFO; a full FIFO holds it back
        pend_next = pend_reg;
        slot_busy = pend_valid_reg && !fifo_ready;
        pend_valid_next = slot_busy;
        overrun_next = overrun_reg;
        if (s3_fire) begin
            if (slot_busy) begin
                overrun_next = 1'b1;
            end else begin
                pend_valid_next = 1'b1;
                pend_next.ch0 = apply_gain(dc_y[0], gain_reg.shift, gain_reg.sat);
                pend_next.ch1 = apply_gain(dc_y[1], gain_reg.shift, gain_reg.sat);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt1_reg <= 3'h0;
            cnt2_reg <= 2'h0;
            cnt3_reg <= 3'h0;
            for (int c = 0; c < 2; c++) begin
                acc1_reg[c] <= 32'sh0;
                acc2_reg[c] <= 32'sh0;
                acc3_reg[c] <= 32'sh0;
                xp_reg[c] <= 32'sh0;
                yp_reg[c] <= 32'sh0;
            end
            pend_reg <= '0;
            pend_valid_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            cnt1_reg <= cnt1_next;
            cnt2_reg <= cnt2_next;
            cnt3_reg <= cnt3_next;
            acc1_reg <= acc1_next;
            acc2_reg <= acc2_next;
            acc3_reg <= acc3_next;
            xp_reg <= xp_next;
            yp_reg <= yp_next;
            pend_reg <= pend_next;
            pend_valid_reg <= pend_valid_next;
            overrun_reg <= overrun_next;
        end
    end

    pmdec_fifo #(
        .WIDTH(2 * SW),
        .DEPTH(`PMDEC_FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_in_valid(pend_valid_reg),
        .o_in_ready(fifo_ready),
        .i_in_data(pend_reg),
        .o_out_valid(o_pcm_valid),
        .i_out_ready(i_pcm_ready),
        .o_out_data(o_pcm)
    );

    assign o_cfg_rd_valid = rd_valid_reg;
    assign o_cfg_shift = rd_shift_reg;
    assign o_cfg_sat = rd_sat_reg;
    assign o_overrun = overrun_reg;

    // Checking helpers: events counted between stage outputs
    logic [3:0] n1_reg, n2_reg, n3_reg;
    logic wr_seen_reg;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            n1_reg <= 4'h0;
            n2_reg <= 4'h0;
            n3_reg <= 4'h0;
            wr_seen_reg <= 1'b0;
        end else begin
            n1_reg <= s1_fire ? 4'h0 : n1_reg + 4'(mic_fall);
            n2_reg <= s2_fire ? 4'h0 : n2_reg + 4'(s1_fire);
            n3_reg <= s3_fire ? 4'h0 : n3_reg + 4'(s2_fire);
            wr_seen_reg <= wr_seen_reg || i_cfg_wr;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    AST_STAGE1_BY8: assert property (s1_fire |-> n1_reg == 4'd7)
        else $error("stage one output not after 8 bits");
    AST_STAGE2_BY4: assert property (s2_fire |-> n2_reg == 4'd3)
        else $error("stage two output not after 4 inputs");
    AST_STAGE3_BY6: assert property (s3_fire |-> n3_reg == 4'd5)
        else $error("stage three output not after 6 inputs");
    AST_FRAME_TO_SLOT: assert property (s3_fire && !slot_busy |=> pend_valid_reg)
        else $error("16 kHz frame not queued");
    AST_DC_STATE: assert property (s3_fire |=> xp_reg[0] == $past(xs[0]))
        else $error("DC blocker input history not updated");
    AST_UNITY_PASS: assert property (s3_fire && !slot_busy && gain_reg.shift == 6'sh0
        |=> pend_reg.ch0 == $past(dc_y[0]))
        else $error("unity gain altered the sample");
    AST_SAT_NO_WRAP: assert property (s3_fire && !slot_busy && gain_reg.sat
        && gain_reg.shift > 6'sh0 |=> pend_reg.ch0[31] == $past(dc_y[0][31]))
        else $error("saturated sample wrapped sign");
    AST_RESET_UNITY: assert property (!wr_seen_reg |-> gain_reg.shift == 6'sh0)
        else $error("shift not zero after reset");
    AST_WRITE_SAT: assert property (i_cfg_wr |=> gain_reg.sat == ($past(i_cfg_sat) != 32'h0))
        else $error("saturate flag not taken from write");
    AST_READ_BACK: assert property (i_cfg_rd |=> o_cfg_rd_valid
        && o_cfg_shift[5:0] == $past(gain_reg.shift) && o_cfg_sat[0] == $past(gain_reg.sat))
        else $error("read answer wrong");

    COV_FRAME: cover property (s3_fire);
    COV_CLAMP: cover property (s3_fire && gain_reg.sat && gain_reg.shift > 6'sh0);
    COV_READ: cover property (i_cfg_wr && i_cfg_rd);
    COV_FULL: cover property (pend_valid_reg && !fifo_ready);

endmodule : pmdec_decimator

// *** design/pmdec_params.svh ***
// Constants for the microphone decimator
`ifndef PMDEC_PARAMS_SVH
`define PMDEC_PARAMS_SVH

`define PMDEC_SAMPLE_W 32
`define PMDEC_DEC1 8
`define PMDEC_DEC2 4
`define PMDEC_DEC3 6
`define PMDEC_DCB_SHIFT 9
`define PMDEC_DCB_IN_SHIFT 22
`define PMDEC_SHIFT_RST 6'h00
`define PMDEC_SAT_RST 1'b0
`define PMDEC_FIFO_DEPTH 32
`define PMDEC_CLK_PERIOD_NS 5
`define PMDEC_BIT_RATE_KHZ 3072

`endif

// *** design/pmdec_pkg.sv ***
// Types shared by the microphone decimator files
package pmdec_pkg;

    typedef struct packed {
        logic signed [31:0] ch1;
        logic signed [31:0] ch0;
    } pmdec_frame_t;

    typedef struct packed {
        logic signed [5:0] shift;
        logic sat;
    } pmdec_gain_t;

endpackage : pmdec_pkg

// *** design/pmdec_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
module pmdec_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input wire logic i_clock,              // System clock
    input wire logic i_arst_n,             // Async reset, active low
    input wire logic i_in_valid,           // Write request
    output logic o_in_ready,               // Not full
    input wire logic [WIDTH-1:0] i_in_data, // Write data
    output logic o_out_valid,              // Not empty
    input wire logic i_out_ready,          // Sink takes word
    output logic [WIDTH-1:0] o_out_data    // Head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic full, empty, push, pop;

    always_comb begin
        full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
        empty = (wr_reg == rd_reg);
        push = i_in_valid && !full;
        pop = i_out_ready && !empty;
        wr_next = push ? wr_reg + (AW+1)'(1) : wr_reg;
        rd_next = pop ? rd_reg + (AW+1)'(1) : rd_reg;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= i_in_data;
        end
    end

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem[rd_reg[AW-1:0]];

endmodule : pmdec_fifo

// *** tb/pmdec_mic_model.sv ***
// Behavioural pair of PDM microphones sharing one data line
module pmdec_mic_model (
    input wire logic i_fast,  // Short bit period for long fills
    input wire logic i_bit0,  // Level sent by mic 0
    input wire logic i_bit1,  // Level sent by mic 1
    output logic o_mic_clk,   // Bit clock to the decimator
    output logic o_mic_data   // Shared data line
);
    timeunit 1ns;
    timeprecision 100ps;
    real half_ns;

    initial begin
        o_mic_clk = 1'b0;
        o_mic_data = 1'b0;
        #3.3;
        forever begin
            half_ns = i_fast ? 20.0 : 62.5;
            #(half_ns) o_mic_clk = 1'b1;
            #(half_ns) o_mic_clk = 1'b0;
        end
    end

    // Mic 1 drives after the rise, mic 0 after the fall
    always @(posedge o_mic_clk) o_mic_data <= #8 i_bit1;
    always @(negedge o_mic_clk) o_mic_data <= #8 i_bit0;
endmodule : pmdec_mic_model

// *** tb/pmdec_decimator_test.sv ***
// Self-checking bench for the microphone decimator
`include "pmdec_params.svh"

module pmdec_decimator_test;
    import pmdec_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock;
    logic i_arst_n;
    logic mic_clk;
    logic mic_data;
    logic fast;
    logic cfg_wr;
    logic cfg_rd;
    logic [31:0] cfg_shift;
    logic [31:0] cfg_sat;
    logic rd_valid;
    logic [31:0] rd_shift;
    logic [31:0] rd_sat;
    logic pcm_valid;
    logic pcm_ready;
    pmdec_frame_t pcm;
    logic overrun;
    int errors = 0;
    int checks_done = 0;
    // Full-scale DC level after the headroom shift, and the least it decays to in this run
    localparam int FS = (`PMDEC_DEC1 * `PMDEC_DEC2 * `PMDEC_DEC3) << `PMDEC_DCB_IN_SHIFT;
    localparam int YLO = FS / 3 * 2;

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    pmdec_mic_model u_pmdec_mic_model (.i_fast(fast), .i_bit0(1'b1), .i_bit1(1'b0),
        .o_mic_clk(mic_clk), .o_mic_data(mic_data));

    pmdec_decimator u_pmdec_decimator (.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_mic_clk(mic_clk), .i_mic_data(mic_data), .i_cfg_wr(cfg_wr),
        .i_cfg_shift(cfg_shift), .i_cfg_sat(cfg_sat), .i_cfg_rd(cfg_rd),
        .o_cfg_rd_valid(rd_valid), .o_cfg_shift(rd_shift), .o_cfg_sat(rd_sat),
        .o_pcm_valid(pcm_valid), .i_pcm_ready(pcm_ready), .o_pcm(pcm),
        .o_overrun(overrun));

    task automatic summarize();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_range(input string name, input logic signed [31:0] lo,
        input logic signed [31:0] hi, input logic signed [31:0] got);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_range

    // Optional write and read in one cycle; a read sees the old gain
    task automatic cfg_op(input logic wr, input logic rd, input logic [31:0] sh,
        input logic [31:0] sat, input logic [31:0] exp_sh, input logic [31:0] exp_sat);
        @(posedge i_clock);
        cfg_wr <= wr;
        cfg_rd <= rd;
        cfg_shift <= sh;
        cfg_sat <= sat;
        @(posedge i_clock);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        if (rd) begin
            check("rd_valid", 32'h1, {31'h0, rd_valid});
            check("rd_shift", exp_sh, rd_shift);
            check("rd_sat", exp_sat, rd_sat);
        end
    endtask : cfg_op

    // Waits for a frame, takes it, returns cycles since the last pop
    task automatic next_frame(output pmdec_frame_t f, output int n);
        n = 0;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while (pcm_valid !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            errors++;
            summarize();
        end
        f = pcm;
        @(posedge i_clock);
    endtask : next_frame

    task automatic t_reset();
        check("pcm_valid", 32'h0, {31'h0, pcm_valid});
        check("overrun", 32'h0, {31'h0, overrun});
        cfg_op(1'b0, 1'b1, 32'h0, 32'h0, 32'h0, 32'h0);
    endtask : t_reset

    task automatic t_config();
        cfg_op(1'b1, 1'b0, 32'hffff_ff3d, 32'h5, 32'h0, 32'h0);
        cfg_op(1'b0, 1'b1, 32'h0, 32'h0, 32'hffff_fffd, 32'h1);
        cfg_op(1'b1, 1'b1, 32'h1f, 32'h0, 32'hffff_fffd, 32'h1);
        cfg_op(1'b1, 1'b1, 32'h2, 32'h8000_0000, 32'h1f, 32'h0);
        cfg_op(1'b1, 1'b1, 32'h0, 32'h0, 32'h2, 32'h1);
    endtask : t_config

    task automatic t_stream();
        pmdec_frame_t f;
        logic signed [31:0] prev0;
        int n;
        next_frame(f, n);
        next_frame(f, n);
        prev0 = 32'sh7fff_ffff;
        repeat (3) begin
            next_frame(f, n);
            check_range("period", 32'sd4799, 32'sd4801, 32'(n + 1));
            check_range("ch0", YLO, FS, f.ch0);
            check_range("ch1", -FS, -YLO, f.ch1);
            check_range("ch0 decay", 32'sd1, prev0 - 32'sd1, f.ch0);
            prev0 = f.ch0;
        end
    endtask : t_stream

    task automatic gain_frame(input logic [31:0] sh, input logic [31:0] sat,
        output pmdec_frame_t f);
        int n;
        cfg_op(1'b1, 1'b0, sh, sat, 32'h0, 32'h0);
        next_frame(f, n);
        next_frame(f, n);
    endtask : gain_frame

    task automatic t_gain();
        pmdec_frame_t f;
        fast <= 1'b1;
        gain_frame(32'h38, 32'h0, f);
        check_range("atten ch0", YLO >>> 8, FS >>> 8, f.ch0);
        check_range("atten ch1", -(FS >>> 8), -(YLO >>> 8), f.ch1);
        gain_frame(32'h1f, 32'h1, f);
        check("sat ch0", 32'h7fff_ffff, f.ch0);
        check("sat ch1", 32'h8000_0000, f.ch1);
        // Times four without clamp pushes both channels across the sign bit
        gain_frame(32'h2, 32'h0, f);
        check_range("wrap ch0", 32'sh8000_0000, 32'shc000_0000, f.ch0);
        check_range("wrap ch1", 32'sh4000_0000, 32'sh7fff_ffff, f.ch1);
        cfg_op(1'b1, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0);
    endtask : t_gain

    // Stall the sink until a frame is lost, then drain 32 plus the slot
    task automatic t_fill();
        int n;
        pcm_ready <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while (overrun !== 1'b1 && n < 60000);
        check("overrun", 32'h1, {31'h0, overrun});
        @(posedge i_clock);
        pcm_ready <= 1'b1;
        n = 0;
        repeat (40) begin
            #1;
            if (pcm_valid === 1'b1) begin
                n++;
            end
            @(posedge i_clock);
        end
        check("drained", 32'd33, 32'(n));
        check("overrun kept", 32'h1, {31'h0, overrun});
    endtask : t_fill

    initial begin
        i_arst_n = 1'b0;
        fast = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_shift = 32'h0;
        cfg_sat = 32'h0;
        pcm_ready = 1'b1;
        repeat (16) @(posedge i_clock);
        i_arst_n <= 1'b1;
        @(posedge i_clock);
        #1;
        t_reset();
        t_config();
        t_stream();
        t_gain();
        t_fill();
        summarize();
    end
endmodule : pmdec_decimator_test
